// ===== out1_cfg_pkg.sv
// ==========================================================
// output channel one configuration constants
package out1_cfg_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0]  DIV_CTRL_OFFSET   = 8'h25; // divider source/value
  localparam logic [7:0]  BUF_SYNC_OFFSET   = 8'h26; // buffer and sync
  localparam logic [7:0]  SWITCH_OFFSET     = 8'h27; // switch mode
  localparam logic [7:0]  SUPPLY_OFFSET     = 8'h28; // supply level
  localparam logic [7:0]  OUT2_RSVD_OFFSET  = 8'h29; // second channel word

  // ==========================================================
  // values after reset
  localparam logic [15:0] DIV_CTRL_RESET    = 16'h8003;
  localparam logic [15:0] BUF_SYNC_RESET    = 16'h0009;
  localparam logic [15:0] SWITCH_RESET      = 16'h0679;
  localparam logic [15:0] SUPPLY_RESET      = 16'h0008;
  localparam logic [15:0] OUT2_RSVD_RESET   = 16'h8000;

  // ==========================================================
  // field positions
  localparam int          ALIGN_DELAY_MSB   = 15;
  localparam int          ALIGN_DELAY_LSB   = 11;
  localparam int          ALIGN_EN_BIT      = 10;
  localparam int          QUIET_SEL_BIT     = 8;
  localparam int          QUIET_BIT         = 7;
  localparam int          FORMAT_MSB        = 4;
  localparam int          FORMAT_LSB        = 2;
  localparam int          SOURCE_MSB        = 1;
  localparam int          SOURCE_LSB        = 0;
  localparam int          SMOOTH_BIT        = 0;
  localparam int          LOW_SUPPLY_BIT    = 3;
  localparam int          DIV_SEL_MSB       = 15;
  localparam int          DIV_SEL_LSB       = 14;
  localparam int          DIV_VAL_MSB       = 13;
  localparam int          DIV_VAL_LSB       = 0;

  // ==========================================================
  // driver format codes
  localparam logic [2:0]  FMT_DISABLED      = 3'h0;
  localparam logic [2:0]  FMT_LVDS          = 3'h1;
  localparam logic [2:0]  FMT_HCSL          = 3'h2;
  localparam logic [2:0]  FMT_CML           = 3'h3;
  localparam logic [2:0]  FMT_LVPECL        = 3'h4;

  // ==========================================================
  // divider input selections
  localparam logic [1:0]  SEL_PRESCALER_A   = 2'h0;
  localparam logic [1:0]  SEL_PRESCALER_B   = 2'h1;
  localparam logic [1:0]  SEL_REFERENCE     = 2'h3;

  // ==========================================================
  // divider state
  typedef enum logic {DIV_RUN, DIV_HOLD} div_state_t;

endpackage : out1_cfg_pkg

// ===== out1_channel_regs.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// RL1: alignment delay in bits 15-11, selected divider input periods
// RL2: bit 10 enables alignment, resets off
// RL3: bit 8 picks muted leg levels
// RL4: bit 7 mutes output, resets unmuted
// RL5: format field 4-2, resets to HCSL
// RL6: switch mode bit 0, resets glitch-free
// RL7: supply flag bit 3, resets to 1.8V
// RL8: divider divides input; zero powers down
// RL9: divider input: prescaler A, B, reference
// RL10: software keeps reserved fields at reset values
// ==========================================================
// output channel one configuration and output path
module out1_channel_regs
  import out1_cfg_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_write,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_read,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        prescaler_a,
  input  wire logic        prescaler_b,
  input  wire logic        ref_clk_in,
  input  wire logic        align_trigger,
  output logic             out1_p,
  output logic             out1_n,
  output logic             out1_drive_en,
  output logic      [2:0]  out1_driver_format,
  output logic             out1_low_supply_flag,
  output logic      [1:0]  out1_source_select
);

  // ==========================================================
  // register storage
  logic [15:0] div_ctrl;          // divider input select and value
  logic [15:0] buf_sync;          // buffer and sync control
  logic [15:0] switch_ctrl;       // switch mode control
  logic [15:0] supply_ctrl;       // supply level control
  logic [15:0] out2_word;         // second channel reserved word
  logic [15:0] next_div_ctrl;
  logic [15:0] next_buf_sync;
  logic [15:0] next_switch_ctrl;
  logic [15:0] next_supply_ctrl;
  logic [15:0] next_out2_word;
  logic [15:0] next_rdata;

  // input synchronisers: align, ref, b, a
  logic [3:0]  sync1;             // first stage, read by sync2 only
  logic [3:0]  sync2;             // second stage
  logic        trig_prev;         // trigger level one cycle ago
  logic        src_level;         // selected divider input
  logic        align_pulse;       // trigger rising edge
  logic        div_out;           // divided clock level
  logic        next_p;
  logic        next_n;
  logic        next_drive_en;

  // ==========================================================
  // register read decode
  function automatic logic [15:0] read_word(input logic [7:0] a,
      input logic [15:0] r25, input logic [15:0] r26,
      input logic [15:0] r27, input logic [15:0] r28,
      input logic [15:0] r29);
    if (a == DIV_CTRL_OFFSET) begin
      return r25;
    end else if (a == BUF_SYNC_OFFSET) begin
      return r26;
    end else if (a == SWITCH_OFFSET) begin
      return r27;
    end else if (a == SUPPLY_OFFSET) begin
      return r28;
    end else if (a == OUT2_RSVD_OFFSET) begin
      return r29;
    end else begin
      return 16'h0000; // unmapped reads as zero
    end
  endfunction : read_word

  // next register values from writes
  always_comb begin
    next_div_ctrl    = div_ctrl;
    next_buf_sync    = buf_sync;
    next_switch_ctrl = switch_ctrl;
    next_supply_ctrl = supply_ctrl;
    next_out2_word   = out2_word;
    // every bit stored, reserved ones kept as written
    if (reg_write) begin
      if (reg_addr == DIV_CTRL_OFFSET) begin
        next_div_ctrl = reg_wdata;
      end else if (reg_addr == BUF_SYNC_OFFSET) begin
        next_buf_sync = reg_wdata;
      end else if (reg_addr == SWITCH_OFFSET) begin
        next_switch_ctrl = reg_wdata;
      end else if (reg_addr == SUPPLY_OFFSET) begin
        next_supply_ctrl = reg_wdata;
      end else if (reg_addr == OUT2_RSVD_OFFSET) begin
        next_out2_word = reg_wdata;
      end
    end
    next_rdata = reg_read ? read_word(reg_addr, div_ctrl, buf_sync,
                                      switch_ctrl, supply_ctrl, out2_word)
                          : reg_rdata;
  end

  // register the bank and read answer
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      div_ctrl    <= DIV_CTRL_RESET;
      buf_sync    <= BUF_SYNC_RESET;    // format HCSL, unmuted, see RL5
      switch_ctrl <= SWITCH_RESET;      // glitch-free default, see RL6
      supply_ctrl <= SUPPLY_RESET;      // 1.8 V default, see RL7
      out2_word   <= OUT2_RSVD_RESET;
      reg_rdata   <= 16'h0000;
      reg_rvalid  <= 1'b0;
    end else begin
      div_ctrl    <= next_div_ctrl;
      buf_sync    <= next_buf_sync;
      switch_ctrl <= next_switch_ctrl;
      supply_ctrl <= next_supply_ctrl;
      out2_word   <= next_out2_word;
      reg_rdata   <= next_rdata;
      reg_rvalid  <= reg_read;
    end
  end

  // ==========================================================
  // input synchronisers and source select
  always_comb begin
    // pick the divider input, see RL9
    if (div_ctrl[DIV_SEL_MSB:DIV_SEL_LSB] == SEL_PRESCALER_A) begin
      src_level = sync2[0];
    end else if (div_ctrl[DIV_SEL_MSB:DIV_SEL_LSB] == SEL_PRESCALER_B) begin
      src_level = sync2[1];
    end else if (div_ctrl[DIV_SEL_MSB:DIV_SEL_LSB] == SEL_REFERENCE) begin
      src_level = sync2[2];
    end else begin
      src_level = 1'b0; // undefined selection stays quiet
    end
    align_pulse = sync2[3] & ~trig_prev;
  end

  // two stage capture of pin levels
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync1     <= 4'h0;
      sync2     <= 4'h0;
      trig_prev <= 1'b0;
    end else begin
      sync1     <= {align_trigger, ref_clk_in, prescaler_b, prescaler_a};
      sync2     <= sync1;
      trig_prev <= sync2[3];
    end
  end

  // ==========================================================
  // channel divider
  out1_divider u_divider (
    .clk_sys       (clk_sys),
    .srst          (srst),
    .src_level     (src_level),
    .align_pulse   (align_pulse),
    .align_enable  (buf_sync[ALIGN_EN_BIT]),
    .align_delay   (buf_sync[ALIGN_DELAY_MSB:ALIGN_DELAY_LSB]),
    .divide_value  (div_ctrl[DIV_VAL_MSB:DIV_VAL_LSB]),
    .smooth_switch (switch_ctrl[SMOOTH_BIT]),
    .div_out       (div_out)
  );

  // ==========================================================
  // output buffer levels
  always_comb begin
    next_p        = 1'b0;
    next_n        = 1'b0;
    next_drive_en = 1'b1;
    if (buf_sync[FORMAT_MSB:FORMAT_LSB] == FMT_DISABLED) begin
      next_drive_en = 1'b0; // buffer off, see RL5
    end else if (buf_sync[QUIET_BIT]) begin
      // muted static levels, see RL4
      next_p = buf_sync[QUIET_SEL_BIT];  // see RL3
      next_n = ~buf_sync[QUIET_SEL_BIT];
    end else begin
      next_p = div_out;
      next_n = ~div_out;
    end
  end

  // register pins and config outputs
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      out1_p               <= 1'b0;
      out1_n               <= 1'b0;
      out1_drive_en        <= 1'b0;
      out1_driver_format   <= FMT_HCSL;
      out1_low_supply_flag <= SUPPLY_RESET[LOW_SUPPLY_BIT];
      out1_source_select   <= BUF_SYNC_RESET[SOURCE_MSB:SOURCE_LSB];
    end else begin
      out1_p               <= next_p;
      out1_n               <= next_n;
      out1_drive_en        <= next_drive_en;
      out1_driver_format   <= buf_sync[FORMAT_MSB:FORMAT_LSB];
      out1_low_supply_flag <= supply_ctrl[LOW_SUPPLY_BIT]; // see RL7
      out1_source_select   <= buf_sync[SOURCE_MSB:SOURCE_LSB];
    end
  end

  // ==========================================================
  // checks
  sequence s_write_buf;
    reg_write && reg_addr == BUF_SYNC_OFFSET;
  endsequence

  property p_quiet_levels;
    @(posedge clk_sys) disable iff (srst)
    (!srst && buf_sync[QUIET_BIT] &&
     buf_sync[FORMAT_MSB:FORMAT_LSB] != FMT_DISABLED)
      |=> out1_p == $past(buf_sync[QUIET_SEL_BIT]) && out1_n != out1_p;
  endproperty
  a_quiet_levels: assert property (p_quiet_levels) // mute, see RL3
    else $error("muted levels wrong");

  property p_unmuted_clock;
    @(posedge clk_sys) disable iff (srst)
    // releasing edge skipped: pins still show reset levels there
    (!srst && !buf_sync[QUIET_BIT] &&
     buf_sync[FORMAT_MSB:FORMAT_LSB] != FMT_DISABLED)
      |=> out1_p == $past(div_out) && out1_drive_en;
  endproperty
  a_unmuted_clock: assert property (p_unmuted_clock) // pass, see RL4
    else $error("unmuted output not following divider");

  property p_format_off;
    @(posedge clk_sys) disable iff (srst)
    (s_write_buf ##1 (buf_sync[FORMAT_MSB:FORMAT_LSB] == FMT_DISABLED))
      |=> !out1_drive_en && !out1_p && !out1_n &&
          out1_driver_format == FMT_DISABLED;
  endproperty
  a_format_off: assert property (p_format_off) // disabled, see RL5
    else $error("disabled format still driving");

  property p_reset_format;
    @(posedge clk_sys) srst |=> out1_driver_format == FMT_HCSL &&
                                !buf_sync[ALIGN_EN_BIT] &&
                                switch_ctrl[SMOOTH_BIT];
  endproperty
  a_reset_format: assert property (p_reset_format) // defaults, see RL5
    else $error("reset defaults wrong");

  property p_supply_flag;
    @(posedge clk_sys) disable iff (srst)
    (reg_write && reg_addr == SUPPLY_OFFSET)
      |=> ##1 out1_low_supply_flag == $past(reg_wdata[LOW_SUPPLY_BIT], 2);
  endproperty
  a_supply_flag: assert property (p_supply_flag) // supply, see RL7
    else $error("supply flag not following register");

  property p_source_ref;
    @(posedge clk_sys) disable iff (srst)
    (div_ctrl[DIV_SEL_MSB:DIV_SEL_LSB] == SEL_REFERENCE)
      |-> src_level == $past(ref_clk_in, 2);
  endproperty
  a_source_ref: assert property (p_source_ref) // input mux, see RL9
    else $error("reference not selected");

endmodule : out1_channel_regs
`default_nettype wire

// ===== out1_divider.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// integer divider with alignment hold and smooth switching
module out1_divider
  import out1_cfg_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        src_level,
  input  wire logic        align_pulse,
  input  wire logic        align_enable,
  input  wire logic [4:0]  align_delay,
  input  wire logic [13:0] divide_value,
  input  wire logic        smooth_switch,
  output logic             div_out
);

  div_state_t  state;        // running or held for alignment
  div_state_t  next_state;
  logic [13:0] cur_div;      // divide value in force
  logic [13:0] next_cur_div;
  logic [13:0] cnt;          // source edges within period
  logic [13:0] next_cnt;
  logic [4:0]  hold_cnt;     // source edges left in hold
  logic [4:0]  next_hold_cnt;
  logic        src_prev;     // source level one cycle ago
  logic        next_out;
  logic        rise;         // source rising edge

  // ==========================================================
  // high part of one output period, rounded up
  function automatic logic [13:0] high_phase(input logic [13:0] d);
    logic [14:0] w;
    w = {1'b0, d} + 15'h0001;
    return w[14:1];
  endfunction : high_phase

  assign rise = src_level & ~src_prev;

  // next divider values
  always_comb begin
    next_state    = state;
    next_cur_div  = cur_div;
    next_cnt      = cnt;
    next_hold_cnt = hold_cnt;
    case (state)
      DIV_RUN: begin
        if (rise && cur_div != 14'h0000) begin
          // count input edges to divide, see RL8
          next_cnt = (cnt >= 14'(cur_div - 14'h0001)) ? 14'h0000
                                                       : 14'(cnt + 14'h0001);
        end
      end
      DIV_HOLD: begin
        next_cnt = 14'h0000;
        if (rise) begin
          // delay counted in selected input periods, see RL1
          if (hold_cnt == 5'h00) begin
            next_state = DIV_RUN;
          end else begin
            next_hold_cnt = 5'(hold_cnt - 5'h01);
          end
        end
      end
      default: next_state = DIV_RUN;
    endcase
    // after counting, so a restart beats an edge in the same cycle
    if (divide_value != cur_div) begin
      if (!smooth_switch) begin
        // immediate change restarts the period, see RL6
        next_cur_div = divide_value;
        next_cnt     = 14'h0000;
      end else if (cur_div == 14'h0000 ||
                   (rise && cnt == 14'(cur_div - 14'h0001))) begin
        // smooth change waits for the period boundary, see RL6
        next_cur_div = divide_value;
      end
    end
    if (align_pulse && align_enable) begin
      // alignment only when the channel takes part, see RL2
      next_state    = DIV_HOLD;
      next_hold_cnt = align_delay;
      next_cnt      = 14'h0000;
    end
    // output level from the coming count
    if (next_cur_div == 14'h0000 || next_state == DIV_HOLD) begin
      next_out = 1'b0; // zero divide value powers down, see RL8
    end else if (next_cur_div == 14'h0001) begin
      next_out = src_level;
    end else begin
      next_out = (next_cnt < high_phase(next_cur_div));
    end
  end

  // register divider state
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state    <= DIV_RUN;
      cur_div  <= DIV_CTRL_RESET[DIV_VAL_MSB:DIV_VAL_LSB];
      cnt      <= 14'h0000;
      hold_cnt <= 5'h00;
      src_prev <= 1'b0;
      div_out  <= 1'b0;
    end else begin
      state    <= next_state;
      cur_div  <= next_cur_div;
      cnt      <= next_cnt;
      hold_cnt <= next_hold_cnt;
      src_prev <= src_level;
      div_out  <= next_out;
    end
  end

  // ==========================================================
  // checks
  sequence s_align_taken;
    align_pulse && align_enable;
  endsequence

  property p_align_hold;
    @(posedge clk_sys) disable iff (srst)
    s_align_taken |=> (state == DIV_HOLD) && !div_out &&
                      (hold_cnt == $past(align_delay));
  endproperty
  a_align_hold: assert property (p_align_hold) // alignment hold, see RL1
    else $error("alignment hold not loaded with delay");

  property p_align_ignored;
    @(posedge clk_sys) disable iff (srst)
    (align_pulse && !align_enable && state == DIV_RUN && !rise)
      |=> state == DIV_RUN;
  endproperty
  a_align_ignored: assert property (p_align_ignored) // gate, see RL2
    else $error("alignment taken while disabled");

  property p_power_down;
    @(posedge clk_sys) disable iff (srst)
    (cur_div == 14'h0000) [*2] |-> !div_out;
  endproperty
  a_power_down: assert property (p_power_down) // divider off, see RL8
    else $error("output active with zero divide value");

  property p_immediate;
    @(posedge clk_sys) disable iff (srst)
    (!smooth_switch && divide_value != cur_div)
      |=> cur_div == $past(divide_value) && cnt == 14'h0000;
  endproperty
  a_immediate: assert property (p_immediate) // instant change, see RL6
    else $error("immediate divider change not applied");

  property p_smooth_waits;
    @(posedge clk_sys) disable iff (srst)
    (smooth_switch && divide_value != cur_div && !rise &&
     cur_div != 14'h0000) |=> $stable(cur_div);
  endproperty
  a_smooth_waits: assert property (p_smooth_waits) // smooth, see RL6
    else $error("smooth change applied mid period");

endmodule : out1_divider
`default_nettype wire

// ===== tb_out1_channel_regs.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// self-checking bench for the channel one register slice
module tb_out1_channel_regs
  import out1_cfg_pkg::*;
;
  logic        clk_sys     = 1'b0;    // 20 MHz system clock
  logic        srst        = 1'b1;    // sync reset, high
  logic [7:0]  reg_addr    = 8'h00;   // register offset
  logic        reg_write   = 1'b0;    // write strobe
  logic [15:0] reg_wdata   = 16'h0000; // write data
  logic        reg_read    = 1'b0;    // read strobe
  logic [15:0] reg_rdata;             // read answer
  logic        reg_rvalid;            // read answer marker
  logic        prescaler_a = 1'b0;    // period 8 cycles
  logic        prescaler_b = 1'b0;    // period 12 cycles
  logic        ref_clk_in  = 1'b0;    // period 20 cycles
  logic        align_trigger = 1'b0;  // alignment request pin
  logic        out1_p;                // positive leg
  logic        out1_n;                // negative leg
  logic        out1_drive_en;         // buffer enable
  logic [2:0]  out1_driver_format;    // format copy
  logic        out1_low_supply_flag;  // supply flag copy
  logic [1:0]  out1_source_select;    // source field copy
  int          fail_count  = 0;       // mismatches seen
  int          comparisons = 0;       // compares made
  logic [4:0]  cnt_a = 5'h00;         // source counters
  logic [4:0]  cnt_b = 5'h00;
  logic [4:0]  cnt_r = 5'h00;
  logic [15:0] v;                     // read value
  int          n;                     // cycle counts
  typedef struct {logic [7:0] a; logic [15:0] w; logic [15:0] e;} row_t;
  // reserved bits written at their reset values, except bits 6-5 at offset 8'h26
  row_t rows [6] = '{'{8'h26, 16'hFDFF, 16'hFDFF}, '{8'h27, 16'h0678, 16'h0678},
    '{8'h28, 16'h0000, 16'h0000}, '{8'h25, 16'h4005, 16'h4005},
    '{8'h29, 16'h8000, 16'h8000}, '{8'h30, 16'hABCD, 16'h0000}};

  // ==========================================================
  // clock and free running source clocks
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cnt_a <= cnt_a + 5'h01;
    cnt_b <= (cnt_b == 5'h0B) ? 5'h00 : cnt_b + 5'h01;
    cnt_r <= (cnt_r == 5'h13) ? 5'h00 : cnt_r + 5'h01;
    prescaler_a <= cnt_a[2];
    prescaler_b <= (cnt_b < 5'h06);
    ref_clk_in  <= (cnt_r < 5'h0A);
  end

  out1_channel_regs i_out1_channel_regs (
    .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .prescaler_a(prescaler_a), .prescaler_b(prescaler_b),
    .ref_clk_in(ref_clk_in), .align_trigger(align_trigger),
    .out1_p(out1_p), .out1_n(out1_n), .out1_drive_en(out1_drive_en),
    .out1_driver_format(out1_driver_format),
    .out1_low_supply_flag(out1_low_supply_flag),
    .out1_source_select(out1_source_select));

  // ==========================================================
  // closing report, the single end of the run
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // compare seen against expected
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      fail_count++;
    end
  endtask : chk

  // one register write, strobe for one cycle
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask : wr

  // one register read, answer one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1;
    chk(reg_rvalid, 16'h0001);
    d = reg_rdata;
  endtask : rd

  // cycles until the next rising edge of out1_p, bounded
  task automatic wait_rise(output int cyc);
    logic prev;
    cyc = 0;
    prev = out1_p;
    @(posedge clk_sys); #1;
    while (!(out1_p === 1'b1 && prev === 1'b0) && cyc < 300) begin
      prev = out1_p;
      cyc++;
      @(posedge clk_sys); #1;
    end
    cyc++;
    if (cyc > 300) begin
      fail_count++;
      give_verdict();
    end
  endtask : wait_rise

  // count cycles with out1_p high over a window
  task automatic count_high(input int len, output int h);
    h = 0;
    repeat (len) begin
      @(posedge clk_sys); #1;
      if (out1_p === 1'b1) h++;
    end
  endtask : count_high

  // measure one output period after settling
  task automatic period_is(input logic [15:0] cfg, input int exp);
    wr(DIV_CTRL_OFFSET, cfg);
    repeat (3) wait_rise(n);
    wait_rise(n);
    chk(n[15:0], exp[15:0]);
  endtask : period_is

  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys); #1;
    chk(out1_driver_format, FMT_HCSL);
    chk(out1_low_supply_flag, 16'h0001);
    chk(out1_source_select, 16'h0001);
    rd(DIV_CTRL_OFFSET, v);  chk(v, 16'h8003);
    rd(BUF_SYNC_OFFSET, v);  chk(v, 16'h0009);
    rd(SWITCH_OFFSET, v);    chk(v, 16'h0679);
    rd(SUPPLY_OFFSET, v);    chk(v, 16'h0008);
    rd(OUT2_RSVD_OFFSET, v); chk(v, 16'h8000);
    // table rows: write, read back, unmapped row reads zero
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, v);
      chk(v, rows[i].e);
    end
    chk(out1_driver_format, 16'h0007);
    chk(out1_low_supply_flag, 16'h0000);
    chk(out1_source_select, 16'h0003);
    // every format code and its drive enable
    for (int f = 0; f < 5; f++) begin
      wr(BUF_SYNC_OFFSET, {11'h000, f[2:0], 2'h1});
      @(posedge clk_sys); #1;
      chk(out1_driver_format, f[15:0]);
      chk(out1_drive_en, (f != 0));
    end
    // divider periods over every source choice
    wr(SWITCH_OFFSET, 16'h0679); // smooth switching first
    period_is(16'h0002, 16);
    period_is(16'h4002, 24);
    period_is(16'hC001, 20);
    wr(SWITCH_OFFSET, 16'h0678);
    period_is(16'h0003, 24);
    wr(DIV_CTRL_OFFSET, 16'h0000);
    repeat (4) @(posedge clk_sys);
    count_high(100, n);
    chk(n[15:0], 16'h0000);
    // mute with both static level choices
    wr(DIV_CTRL_OFFSET, 16'h0002);
    wr(BUF_SYNC_OFFSET, 16'h0089);
    count_high(40, n);
    chk(n[15:0], 16'h0000);
    chk(out1_n, 16'h0001);
    wr(BUF_SYNC_OFFSET, 16'h0189);
    count_high(40, n);
    chk(n[15:0], 16'h0028);
    chk(out1_n, 16'h0000);
    // alignment request ignored while disabled, then held
    for (int en = 0; en < 2; en++) begin
      wr(BUF_SYNC_OFFSET, {5'h05, en[0], 10'h009});
      wait_rise(n);
      @(posedge clk_sys);
      align_trigger <= 1'b1;
      repeat (4) @(posedge clk_sys);
      align_trigger <= 1'b0;
      repeat (4) @(posedge clk_sys);
      count_high(32, n);
      chk((n == 0), (en == 1));
    end
    count_high(40, n);
    chk((n > 0), 16'h0001);
    // reset in mid run restores the reset values
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    rd(BUF_SYNC_OFFSET, v); chk(v, 16'h0009);
    chk(out1_low_supply_flag, 16'h0001);
    give_verdict();
  end
endmodule : tb_out1_channel_regs
`default_nettype wire
